// ---- rtl/tx_client_pkg.sv ----
// shared constants for the transmit client stream source
package tx_client_pkg;
  localparam int WORD_BITS      = 64;
  localparam int WORDS_40G      = 4;
  localparam int WORDS_100G     = 8;
  localparam int NATIVE_40G     = 128;
  localparam int NATIVE_100G    = 320;
  localparam int ADAPTED_40G    = 256;
  localparam int ADAPTED_100G   = 512;
  localparam int BYTES_PER_WORD = 8;
  localparam int CLK_MHZ        = 250;
  localparam int MIN_CLK_MHZ    = 315;
  localparam int PTP_CFG_OFFSET = 12'h125;
  localparam int PTP_CFG_BIT    = 1;
  localparam logic [7:0] START_BYTE = 8'hFB;
  localparam logic [7:0] PREAMBLE_BYTE = 8'h55;
  localparam logic [7:0] SFD_BYTE = 8'hD5;
  localparam int PREAMBLE_BYTES = 8;
  localparam int STABLE_SYNC_STAGES = 2;
  typedef enum logic [1:0] {
    ST_WAIT_STABLE,
    ST_IDLE,
    ST_SEND
  } src_state_t;
endpackage : tx_client_pkg

// ---- rtl/sync2.sv ----
// two flip-flop synchroniser for a level
`timescale 1ns/1ps
`default_nettype none
module sync2
(
  input  wire logic clk_sys_in,
  input  wire logic rst_in,
  input  wire logic level_in,
  output var  logic level_out
);
  logic meta;
  logic next_meta;
  logic next_level;

  always_comb
  begin
    next_meta  = rst_in ? 1'b0 : level_in;
    next_level = rst_in ? 1'b0 : meta;
  end

  always_ff @(posedge clk_sys_in)
  begin
    meta      <= next_meta;
    level_out <= next_level;
  end
endmodule : sync2
`default_nettype wire

// ---- rtl/tx_client_source.sv ----
// packet source driving the mac transmit client stream port
// Overview of operation
// - native bus is 128 bits for 40G, 320 bits for 100G.
// - adapted client bus is 256 bits for 40G, 512 bits for 100G.
// - client clock above 315 MHz, or 190.90 MHz in reduced variants; the bench clock runs at 250 MHz.
// - all stream signals are synchronous to the mac transmit clock.
// - first packet byte sits in the top byte lane of sop word.
// - while ready is low the source holds data and control stable.
// - data, sop, eop and empty count only while valid is high.
// - packet words go in consecutive accepted cycles; source buffers first. No buffer here: each word is read from pkt_word_in as it is sent.
// - valid stays high from sop cycle through eop cycle.
// - empty gives unused trailing byte lanes in eop cycle.
// - with pass-through on, packets begin with the preamble.
// - no packets until transmit lanes are stable after reset.
// - pass-through is bit 1 of configuration register 0x125.
`timescale 1ns/1ps
`default_nettype none
module tx_client_source
  import tx_client_pkg::*;
#(
  parameter int WORDS      = WORDS_40G,
  parameter int MAX_WORDS  = 256,
  parameter int EMPTY_W    = $clog2(BYTES_PER_WORD * WORDS),
  parameter int DATA_W     = WORDS * WORD_BITS,
  parameter int LEN_W      = 16
)
(
  input  wire logic              clk_sys_in,
  input  wire logic              rst_in,
  // user side: one packet request, payload bytes fetched by word index
  input  wire logic              pkt_req_in,
  input  wire logic [LEN_W-1:0]  pkt_len_in,
  input  wire logic              pkt_err_in,
  input  wire logic              preamble_on_in,
  input  wire logic [DATA_W-1:0] pkt_word_in,
  output var  logic              pkt_busy_out,
  output var  logic              pkt_done_out,
  output var  logic [LEN_W-1:0]  pkt_word_idx_out,
  // lane status from the mac, another domain
  input  wire logic              lanes_stable_in,
  // stream port towards the mac
  input  wire logic              tx_ready_in,
  output var  logic [DATA_W-1:0] tx_data_out,
  output var  logic              tx_valid_out,
  output var  logic              tx_startofpacket_out,
  output var  logic              tx_endofpacket_out,
  output var  logic [EMPTY_W-1:0] tx_empty_out,
  output var  logic              tx_error_out
);
  localparam int BYTES = BYTES_PER_WORD * WORDS;
  localparam logic [LEN_W-1:0] BYTES_L = LEN_W'(BYTES);
  localparam logic [LEN_W-1:0] MAX_BYTES_L = LEN_W'(MAX_WORDS * BYTES);
  localparam logic [WORD_BITS-1:0] PREAMBLE_WORD =
    {START_BYTE, {6{PREAMBLE_BYTE}}, SFD_BYTE};

  logic               lanes_stable;

  // packet control group
  src_state_t         state;
  src_state_t         next_state;
  logic [LEN_W-1:0]   words_left;
  logic [LEN_W-1:0]   next_words_left;
  logic [LEN_W-1:0]   idx;
  logic [LEN_W-1:0]   next_idx;
  logic [EMPTY_W-1:0] last_empty;
  logic [EMPTY_W-1:0] next_last_empty;
  logic               err_lat;
  logic               next_err_lat;
  logic               next_busy;
  logic               next_done;

  // stream output group
  logic [DATA_W-1:0]  next_data;
  logic               next_valid;
  logic               next_sop;
  logic               next_eop;
  logic [EMPTY_W-1:0] next_empty;
  logic               next_error;

  // user word index group
  logic [LEN_W-1:0]   next_word_idx;

  // request decode
  logic [LEN_W-1:0]   total;
  logic [LEN_W-1:0]   rem;
  logic [LEN_W-1:0]   first_words;
  logic [EMPTY_W-1:0] first_empty;
  logic [DATA_W-1:0]  first_data;
  logic               len_ok;
  logic               take;
  logic               take_last;
  logic               accept;
  logic               finish;
  logic               advance;
  logic               advance_last;

  // lane status crosses from the mac domain
  sync2 u_stable_sync
  (
    .clk_sys_in (clk_sys_in),
    .rst_in     (rst_in),
    .level_in   (lanes_stable_in),
    .level_out  (lanes_stable)
  );

  // word accepted by the mac in this cycle
  assign accept = tx_valid_out & tx_ready_in;

  // packet size on the bus, with preamble when pass-through is on
  always_comb
  begin
    total = preamble_on_in ? LEN_W'(pkt_len_in + LEN_W'(PREAMBLE_BYTES))
                           : pkt_len_in;
    rem         = total % BYTES_L;
    first_words = LEN_W'((total + BYTES_L - 1'b1) / BYTES_L);
    first_empty = (rem == '0) ? '0 : EMPTY_W'(BYTES_L - rem);
    // empty or oversized requests are dropped without notice
    len_ok      = (pkt_len_in != '0) && (pkt_len_in <= MAX_BYTES_L) &&
                  (total <= MAX_BYTES_L);
  end

  // first word, preamble in the top lane when pass-through is on
  always_comb
  begin
    first_data = pkt_word_in;
    if (preamble_on_in)
      first_data[DATA_W-1 -: WORD_BITS] = PREAMBLE_WORD;
  end

  // request taken only from idle once the lanes are stable
  assign take      = (state == ST_IDLE) && lanes_stable &&
                     pkt_req_in && len_ok;
  assign take_last = (first_words == LEN_W'(1));

  // accepted word closes or continues the packet
  assign finish       = (state == ST_SEND) && accept && tx_endofpacket_out;
  assign advance      = (state == ST_SEND) && accept && !tx_endofpacket_out;
  assign advance_last = (words_left == LEN_W'(2));

  // packet control: state, word count, index, tail information
  always_comb
  begin
    next_state      = state;
    next_words_left = words_left;
    next_idx        = idx;
    next_last_empty = last_empty;
    next_err_lat    = err_lat;
    next_busy       = pkt_busy_out;
    next_done       = 1'b0;
    unique case (state)
      ST_WAIT_STABLE:
      begin
        if (lanes_stable)
          next_state = ST_IDLE;
      end

      ST_IDLE:
      begin
        if (!lanes_stable)
          next_state = ST_WAIT_STABLE;
        else if (take)
        begin
          // user holds payload ready, so the packet streams gaplessly
          next_words_left = first_words;
          next_last_empty = first_empty;
          next_err_lat    = pkt_err_in;
          next_idx        = '0;
          next_busy       = 1'b1;
          next_state      = ST_SEND;
        end
      end

      ST_SEND:
      begin
        // lanes dropping mid-packet do not cut the packet short
        if (finish)
        begin
          next_words_left = '0;
          next_idx        = '0;
          next_busy       = 1'b0;
          next_done       = 1'b1;
          next_state      = ST_IDLE;
        end
        else if (advance)
        begin
          next_words_left = words_left - 1'b1;
          next_idx        = idx + 1'b1;
        end
      end
      default:
        next_state = ST_WAIT_STABLE;
    endcase
    if (rst_in)
    begin
      next_state      = ST_WAIT_STABLE;
      next_words_left = '0;
      next_idx        = '0;
      next_last_empty = '0;
      next_err_lat    = 1'b0;
      next_busy       = 1'b0;
      next_done       = 1'b0;
    end
  end

  // stream outputs, everything held while a valid word waits with ready low
  always_comb
  begin
    next_data  = tx_data_out;
    next_valid = tx_valid_out;
    next_sop   = tx_startofpacket_out;
    next_eop   = tx_endofpacket_out;
    next_empty = tx_empty_out;
    next_error = tx_error_out;
    if (take)
    begin
      next_valid = 1'b1;
      next_sop   = 1'b1;
      next_data  = first_data;
      next_eop   = take_last;
      next_empty = take_last ? first_empty : '0;
      next_error = take_last & pkt_err_in;
    end
    else if (finish)
    begin
      next_valid = 1'b0;
      next_sop   = 1'b0;
      next_eop   = 1'b0;
      next_empty = '0;
      next_error = 1'b0;
    end
    else if (advance)
    begin
      next_valid = 1'b1;
      next_sop   = 1'b0;
      next_data  = pkt_word_in;
      next_eop   = advance_last;
      next_empty = advance_last ? last_empty : '0;
      next_error = advance_last & err_lat;
    end
    else if (state != ST_SEND)
      next_valid = 1'b0;
    if (rst_in)
    begin
      next_data  = '0;
      next_valid = 1'b0;
      next_sop   = 1'b0;
      next_eop   = 1'b0;
      next_empty = '0;
      next_error = 1'b0;
    end
  end

  // word source is read combinationally, so the index leads by one
  always_comb
  begin
    next_word_idx = '0;
    if (next_state == ST_SEND)
      next_word_idx = next_idx + 1'b1;
    if (rst_in)
      next_word_idx = '0;
  end

  // packet control registers
  always_ff @(posedge clk_sys_in)
  begin
    state        <= next_state;
    words_left   <= next_words_left;
    idx          <= next_idx;
    last_empty   <= next_last_empty;
    err_lat      <= next_err_lat;
    pkt_busy_out <= next_busy;
    pkt_done_out <= next_done;
  end

  // stream output registers
  always_ff @(posedge clk_sys_in)
  begin
    tx_data_out          <= next_data;
    tx_valid_out         <= next_valid;
    tx_startofpacket_out <= next_sop;
    tx_endofpacket_out   <= next_eop;
    tx_empty_out         <= next_empty;
    tx_error_out         <= next_error;
  end

  // user word index register
  always_ff @(posedge clk_sys_in)
  begin
    pkt_word_idx_out <= next_word_idx;
  end
endmodule : tx_client_source
`default_nettype wire

// ---- tb/tx_client_props.sv ----
// checker for the client stream source
`timescale 1ns/1ps
`default_nettype none
module tx_client_props #(parameter int DATA_W = 256)
(
  input wire logic clk_sys_in,
  input wire logic rst_in,
  input wire logic lanes_stable_in,
  input wire logic tx_ready_in,
  input wire logic [DATA_W-1:0] tx_data_out,
  input wire logic tx_valid_out,
  input wire logic tx_startofpacket_out,
  input wire logic tx_endofpacket_out,
  input wire logic tx_error_out,
  input wire logic pkt_done_out
);
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (rst_in);
  a_hold_stall: assert property (tx_valid_out && !tx_ready_in |=>
    $stable({tx_valid_out, tx_data_out, tx_startofpacket_out,
    tx_endofpacket_out, tx_error_out})) else $error("moved in stall");
  a_valid_run: assert property (tx_valid_out && !tx_endofpacket_out |=>
    tx_valid_out) else $error("gap in packet");
  a_error_eop: assert property (tx_error_out |-> tx_endofpacket_out)
    else $error("error off end");
  a_lanes_wait: assert property ($fell(rst_in) ##0
    !lanes_stable_in [*4] |-> !tx_valid_out) else $error("early send");
  a_marks_valid: assert property (tx_startofpacket_out |
    tx_endofpacket_out |-> tx_valid_out) else $error("mark without valid");
  a_mid_sop: assert property (tx_valid_out && tx_ready_in &&
    !tx_endofpacket_out |=> !tx_startofpacket_out) else $error("restart");
  a_end_done: assert property (tx_valid_out && tx_ready_in &&
    tx_endofpacket_out |=> pkt_done_out && !tx_valid_out) else $error("end");
  a_start_sop: assert property ($rose(tx_valid_out) |->
    tx_startofpacket_out) else $error("no start mark");
endmodule // tx_client_props
bind tx_client_source tx_client_props #(.DATA_W(DATA_W)) i_props
  (.clk_sys_in, .rst_in, .lanes_stable_in, .tx_ready_in, .tx_data_out,
  .tx_valid_out, .tx_startofpacket_out, .tx_endofpacket_out, .tx_error_out,
  .pkt_done_out);
`default_nettype wire

// ---- tb/mac_sink_model.sv ----
// mac sink model: ready with stalls, lane status
`timescale 1ns/1ps
`default_nettype none
module mac_sink_model
(
  input wire logic clk_sys_in,
  input wire logic rst_in,
  input wire logic slow_in,
  input wire logic lanes_go_in,
  output var logic ready_out,
  output var logic lanes_stable_out
);
  logic [1:0] tick;
  always_ff @(posedge clk_sys_in)
  begin
    tick <= rst_in ? 2'h0 : tick + 2'h1;
    lanes_stable_out <= !rst_in && lanes_go_in;
    ready_out <= !rst_in && (!slow_in || tick == 2'h2);
  end
endmodule // mac_sink_model
`default_nettype wire

// ---- tb/tx_client_source_tb.sv ----
// bench for the client stream source
`timescale 1ns/1ps
`default_nettype none
module tx_client_source_tb;
  import tx_client_pkg::*;
  localparam int DW = WORDS_40G * WORD_BITS;
  logic clk_sys_in = 1'b0, rst_in = 1'b1, req = 1'b0, err = 1'b0;
  logic pre = 1'b0, slow = 1'b0, go = 1'b0, busy, done, ready, lanes;
  logic valid, sop, eop, terr;
  logic [15:0] len = 16'h0000, idx;
  logic [DW-1:0] data, word;
  logic [4:0] empty;
  int err_total = 0, check_count = 0, cyc = 0;
  always #2 clk_sys_in = ~clk_sys_in;
  assign word = {16{idx ^ 16'hA500}};
  tx_client_source i_dut (.clk_sys_in, .rst_in, .pkt_req_in(req),
    .pkt_len_in(len), .pkt_err_in(err), .preamble_on_in(pre),
    .pkt_word_in(word), .pkt_busy_out(busy), .pkt_done_out(done),
    .pkt_word_idx_out(idx), .lanes_stable_in(lanes), .tx_ready_in(ready),
    .tx_data_out(data), .tx_valid_out(valid), .tx_startofpacket_out(sop),
    .tx_endofpacket_out(eop), .tx_empty_out(empty), .tx_error_out(terr));
  mac_sink_model i_mac (.clk_sys_in, .rst_in, .slow_in(slow),
    .lanes_go_in(go), .ready_out(ready), .lanes_stable_out(lanes));
  task automatic check(input logic ok, input string what);
    check_count++;
    err_total += int'(ok !== 1'b1);
    if (ok !== 1'b1)
      $display("mismatch at %0t: %s", $time, what);
  endtask
  task automatic wrap_up(input int hung);
    err_total += hung;
    $display("mismatches %0d checks %0d", err_total, check_count);
    if (err_total == 0 && check_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // one packet: request, then judge every accepted word
  task automatic run_pkt(input logic [15:0] n, input logic e, input logic p);
    int b, w, k;
    logic [DW-1:0] x;
    b = int'(n) + (p ? 8 : 0);
    w = (b + 31) / 32;
    k = 0;
    @(posedge clk_sys_in);
    {req, len, err, pre} <= {1'b1, n, e, p};
    @(posedge clk_sys_in);
    req <= 1'b0;
    for (int t = 0; t < 99 && k < w; t++)
    begin
      @(posedge clk_sys_in);
      x = {16{16'(k) ^ 16'hA500}};
      if (p && k == 0)
        x[DW-1 -: 64] = {START_BYTE, {6{PREAMBLE_BYTE}}, SFD_BYTE};
      if ((valid & ready) === 1'b1)
      begin
        check(sop === (k == 0) && eop === (k == w - 1), "marks");
        check(busy === 1'b1 && terr === (e && k == w - 1), "err");
        check(data === x, "data");
        if (k == w - 1)
          check(empty === 5'(w * 32 - b) && terr === e, "tail");
        k++;
      end
    end
    @(posedge clk_sys_in);
    check(k == w && done === 1'b1 && valid === 1'b0, "end");
    check(busy === 1'b0, "still busy");
  endtask
  task automatic t_lanes();
    @(posedge clk_sys_in);
    {req, len} <= {1'b1, 16'h0028};
    repeat (20) @(posedge clk_sys_in);
    check(valid === 1'b0 && busy === 1'b0, "early send");
    {req, go} <= 2'b01;
    repeat (6) @(posedge clk_sys_in);
  endtask
  initial
  begin
    repeat (12) @(posedge clk_sys_in);
    rst_in <= 1'b0;
    t_lanes();
    run_pkt(16'h0028, 1'b0, 1'b0);
    slow <= 1'b1;
    run_pkt(16'h005A, 1'b0, 1'b0);
    slow <= 1'b0;
    run_pkt(16'h0020, 1'b1, 1'b0);
    run_pkt(16'h0046, 1'b1, 1'b0);
    run_pkt(16'h003C, 1'b0, 1'b1);
    wrap_up(0);
  end
  always @(posedge clk_sys_in)
    if (++cyc == 2000)
      wrap_up(1);
endmodule // tx_client_source_tb
`default_nettype wire
